// [src/dps_map.vh]
// register offsets, field positions, reset values and timing for the supervisor
`ifndef DPS_MAP_VH
`define DPS_MAP_VH
`define DPS_ADDR_W 4
`define DPS_A_STALL_CFG 4'h0
`define DPS_A_STALL_LVL 4'h1
`define DPS_A_STALL_TIME 4'h2
`define DPS_A_OL_CFG 4'h3
`define DPS_A_OL_ACT 4'h4
`define DPS_A_PL_CFG 4'h5
`define DPS_A_OT_CFG 4'h6
`define DPS_A_OT_LVL 4'h7
`define DPS_A_OT_TIME 4'h8
`define DPS_A_LT_CFG 4'h9
`define DPS_A_LT_LVL 4'ha
`define DPS_A_LT_TIME 4'hb
`define DPS_A_RELAY 4'hc
`define DPS_A_STATUS 4'hd
`define DPS_A_CTRL 4'he
`define DPS_STALL_RUN_DIS_BIT 2
`define DPS_STALL_DEC2_BIT 3
`define DPS_OL_EN_BIT 0
`define DPS_OL_HOT_BIT 1
`define DPS_OL_FORCED_BIT 2
`define DPS_STALL_CFG_RST 4'h0
`define DPS_STALL_LVL_RST 16'h0096
`define DPS_STALL_TIME_RST 16'h0064
`define DPS_OL_CFG_RST 4'h1
`define DPS_OT_LVL_RST 16'h0096
`define DPS_OT_TIME_RST 16'h0001
`define DPS_LT_LVL_RST 16'h001e
`define DPS_LT_TIME_RST 16'h0001
`define DPS_RELAY_RST 5'h00
`define DPS_FN_TORQUE_A 5'h0c
`define DPS_FN_TORQUE_B 5'h19
`define DPS_MODE_VF 2'h0
`define DPS_MODE_SV 2'h2
`define DPS_STALL_HYST 16'h0002
`define DPS_IN_LOSS_MIN 16'h001e
`define DPS_OUT_LOSS_MIN 16'h000a
`define DPS_CLK_HZ 100000000
`define DPS_MS_CYC (`DPS_CLK_HZ / 1000)
`define DPS_DS_CYC (`DPS_CLK_HZ / 10)
`define DPS_COLD_S 330
`define DPS_HOT_S 210
`define DPS_OL_PCT_REF 16'h0096
`endif

// [src/dps_supervisor.v]
// protection supervisor: stall fold-back, overload, phase loss, torque
// Contract
// (R1) current above run stall level for detection time lowers frequency.
// (R2) below stall level minus two percent, ramp back up to reference.
// (R3) run stall acts only in volts-per-hertz or sensorless vector mode.
// (R4) stall config bit 2 zero enables run stall, one disables it.
// (R5) overload cfg: bit0 enable, bit1 hot start, bit2 force-cooled.
// (R6) thermal accumulator cleared at every power-up.
// (R7) cold start trips after 5.5 minutes at 150 percent above 60 Hz.
// (R8) hot start trips after 3.5 minutes at 150 percent above 60 Hz.
// (R9) force-cooled threshold rated current 6-60 Hz, 83 percent below 1 Hz.
// (R10) standard threshold 70 percent at 20 Hz, 40 percent below 1 Hz.
// (R11) stop-on-overload cuts output and latches fault until reset.
// (R12) continue-on-overload keeps running, alarm until current normal.
// (R13) input phase loss trips with fault contact; ignored below 30 percent.
// (R14) output phase loss trips with fault contact; ignored below 10 percent.
// (R15) over-torque select: 0 off, 1 at set frequency, 2 while running.
// (R16) over-torque when load stays above level for the set time.
// (R17) over-torque action: 0 fault decel, 1 alarm, 2 fault coast.
// (R18) low-torque select: 0 off, 1 at set frequency, 2 while running.
// (R19) low torque when load stays below level for the set time.
// (R20) low-torque action: 0 fault decel, 1 alarm, 2 fault coast.
// (R21) levels use rated current in V/f, rated torque in sensorless vector.
// (R22) relay shows torque detection when its function code is 12 or 25.
// (R23) each detection timer restarts when its condition drops early.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "dps_map.vh"
module dps_supervisor #(
    parameter N_RELAY = 3,
    parameter [47:0] COLD_CYC = 48'd1 * `DPS_COLD_S * `DPS_CLK_HZ,
    parameter [47:0] HOT_CYC = 48'd1 * `DPS_HOT_S * `DPS_CLK_HZ
) (
    input wire i_mclk,
    input wire i_rst,
    input wire [`DPS_ADDR_W-1:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [15:0] o_rdata,
    input wire [1:0] i_ctrl_mode,
    input wire i_running,
    input wire i_at_set_freq,
    input wire i_accel,
    input wire [15:0] i_cur_pct,
    input wire [15:0] i_torque_pct,
    input wire [15:0] i_freq_dhz,
    input wire i_in_phase_lost,
    input wire i_out_phase_lost,
    input wire i_fault_reset,
    output reg o_stall_decel,
    output reg o_stall_decel2,
    output reg o_stall_recover,
    output wire o_output_off,
    output wire o_decel_stop,
    output wire o_fault_contact,
    output reg o_motor_overload_fault,
    output reg o_overload_alarm,
    output reg o_input_phase_loss_fault,
    output reg o_output_phase_loss_fault,
    output reg o_ot_fault,
    output reg o_ot_alarm,
    output reg o_lt_fault,
    output reg o_lt_alarm,
    output reg [N_RELAY-1:0] o_relay
);
// ----------------------------------------
// configuration registers
// ----------------------------------------
    reg [3:0] stall_cfg;
    reg [15:0] stall_lvl;
    reg [15:0] stall_time;
    reg [3:0] ol_cfg;
    reg ol_continue;
    reg [1:0] pl_cfg;
    reg [1:0] ot_sel;
    reg [1:0] ot_act;
    reg [15:0] ot_lvl;
    reg [15:0] ot_time;
    reg [1:0] lt_sel;
    reg [1:0] lt_act;
    reg [15:0] lt_lvl;
    reg [15:0] lt_time;
    reg [5*N_RELAY-1:0] relay_fn;
    reg soft_reset;
    wire [15:0] status;
    integer k;
    always @(posedge i_mclk) begin
        if (i_rst) begin
            stall_cfg <= `DPS_STALL_CFG_RST;
            stall_lvl <= `DPS_STALL_LVL_RST;
            stall_time <= `DPS_STALL_TIME_RST;
            ol_cfg <= `DPS_OL_CFG_RST;
            ol_continue <= 1'b0;
            pl_cfg <= 2'h0;
            ot_sel <= 2'h0;
            ot_act <= 2'h0;
            ot_lvl <= `DPS_OT_LVL_RST;
            ot_time <= `DPS_OT_TIME_RST;
            lt_sel <= 2'h0;
            lt_act <= 2'h0;
            lt_lvl <= `DPS_LT_LVL_RST;
            lt_time <= `DPS_LT_TIME_RST;
            relay_fn <= {N_RELAY{`DPS_RELAY_RST}};
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= 1'b0;
            if (i_wr) begin
                case (i_addr)
                    `DPS_A_STALL_CFG: stall_cfg <= i_wdata[3:0];
                    `DPS_A_STALL_LVL: stall_lvl <= i_wdata;
                    `DPS_A_STALL_TIME: stall_time <= i_wdata;
                    `DPS_A_OL_CFG: ol_cfg <= {1'b0, i_wdata[2:0]}; // R5
                    `DPS_A_OL_ACT: ol_continue <= i_wdata[0];
                    `DPS_A_PL_CFG: pl_cfg <= i_wdata[1:0];
                    `DPS_A_OT_CFG: begin
                        ot_sel <= i_wdata[1:0];
                        ot_act <= i_wdata[5:4];
                    end
                    `DPS_A_OT_LVL: ot_lvl <= i_wdata;
                    `DPS_A_OT_TIME: ot_time <= i_wdata;
                    `DPS_A_LT_CFG: begin
                        lt_sel <= i_wdata[1:0];
                        lt_act <= i_wdata[5:4];
                    end
                    `DPS_A_LT_LVL: lt_lvl <= i_wdata;
                    `DPS_A_LT_TIME: lt_time <= i_wdata;
                    `DPS_A_RELAY: begin
                        for (k = 0; k < N_RELAY; k = k + 1) begin
                            if (i_wdata[15:12] == k[3:0]) begin
                                relay_fn[5*k +: 5] <= i_wdata[4:0];
                            end
                        end
                    end
                    `DPS_A_CTRL: soft_reset <= i_wdata[0];
                    default: ;
                endcase
            end
        end
    end

    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            case (i_addr)
                `DPS_A_STALL_CFG: o_rdata <= {12'h000, stall_cfg};
                `DPS_A_STALL_LVL: o_rdata <= stall_lvl;
                `DPS_A_STALL_TIME: o_rdata <= stall_time;
                `DPS_A_OL_CFG: o_rdata <= {12'h000, ol_cfg};
                `DPS_A_OL_ACT: o_rdata <= {15'h0000, ol_continue};
                `DPS_A_PL_CFG: o_rdata <= {14'h0000, pl_cfg};
                `DPS_A_OT_CFG: o_rdata <= {10'h000, ot_act, 2'h0, ot_sel};
                `DPS_A_OT_LVL: o_rdata <= ot_lvl;
                `DPS_A_OT_TIME: o_rdata <= ot_time;
                `DPS_A_LT_CFG: o_rdata <= {10'h000, lt_act, 2'h0, lt_sel};
                `DPS_A_LT_LVL: o_rdata <= lt_lvl;
                `DPS_A_LT_TIME: o_rdata <= lt_time;
                `DPS_A_STATUS: o_rdata <= status;
                default: o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end
// ----------------------------------------
// run stall prevention
// ----------------------------------------
    wire mode_ok = (i_ctrl_mode == `DPS_MODE_VF) ||
                   (i_ctrl_mode == `DPS_MODE_SV); // R3
    wire stall_en = !stall_cfg[`DPS_STALL_RUN_DIS_BIT] && mode_ok &&
                    i_running && !i_accel; // R4
    wire stall_hit;
    wire [15:0] stall_low = (stall_lvl > `DPS_STALL_HYST) ?
                            stall_lvl - `DPS_STALL_HYST : 16'h0000;
    dps_timer #(.TICK_CYC(`DPS_MS_CYC), .W(16)) u_stall (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_cond(stall_en && (i_cur_pct > stall_lvl)),
        .i_limit(stall_time),
        .o_hit(stall_hit)
    );
    always @(posedge i_mclk) begin
        if (i_rst || !stall_en) begin
            o_stall_decel <= 1'b0;
            o_stall_decel2 <= 1'b0;
            o_stall_recover <= 1'b0;
        end else if (stall_hit) begin
            o_stall_decel <= 1'b1; // R1
            o_stall_decel2 <= stall_cfg[`DPS_STALL_DEC2_BIT]; // R1
            o_stall_recover <= 1'b0;
        end else if (o_stall_decel && (i_cur_pct < stall_low)) begin
            o_stall_decel <= 1'b0; // R2
            o_stall_decel2 <= 1'b0;
            o_stall_recover <= 1'b1; // R2
        end else if (o_stall_recover && i_at_set_freq) begin
            o_stall_recover <= 1'b0;
        end
    end
// ----------------------------------------
// motor overload thermal accumulator
// ----------------------------------------
    // threshold in percent of rated current, by output frequency (0.1 Hz)
    function [15:0] ol_thresh;
        input forced;
        input [15:0] f;
        begin
            if (forced) begin
                if (f < 16'h000a) ol_thresh = 16'h0053; // R9
                else if (f >= 16'h003c) ol_thresh = 16'h0064; // R9
                else ol_thresh = 16'h0053 + ((f - 16'h000a) * 16'h0011)
                                 / 16'h0032;
            end else begin
                if (f < 16'h000a) ol_thresh = 16'h0028; // R10
                else if (f < 16'h00c8) ol_thresh = 16'h0028 +
                    ((f - 16'h000a) * 16'h001e) / 16'h00be; // R10
                else if (f >= 16'h0258) ol_thresh = 16'h0064;
                else ol_thresh = 16'h0046 + ((f - 16'h00c8) * 16'h001e)
                                 / 16'h0190;
            end
        end
    endfunction
    wire [15:0] ol_lvl = ol_thresh(ol_cfg[`DPS_OL_FORCED_BIT], i_freq_dhz);
    wire ol_over = ol_cfg[`DPS_OL_EN_BIT] && (i_cur_pct > ol_lvl);
    // heating rate scales with excess over threshold; 50 percent is nominal
    wire [15:0] excess = i_cur_pct - ol_lvl;
    wire [47:0] ol_limit = ol_cfg[`DPS_OL_HOT_BIT] ? HOT_CYC : COLD_CYC;
    reg [47:0] ol_acc;
    wire reset_req = i_fault_reset || soft_reset;
    always @(posedge i_mclk) begin
        if (i_rst) begin
            ol_acc <= 48'h0; // R6
            o_motor_overload_fault <= 1'b0;
            o_overload_alarm <= 1'b0;
        end else begin
            if (ol_over) begin
                ol_acc <= ol_acc + {32'h0, excess} / 48'h32; // R7 R8
            end else if (ol_acc != 48'h0) begin
                ol_acc <= ol_acc - 48'h1;
            end
            if (ol_over && (ol_acc >= ol_limit) && !ol_continue) begin
                o_motor_overload_fault <= 1'b1; // R11
            end else if (reset_req) begin
                o_motor_overload_fault <= 1'b0; // R11
            end
            if (ol_continue) begin
                o_overload_alarm <= ol_over && (ol_acc >= ol_limit); // R12
            end else begin
                o_overload_alarm <= 1'b0;
            end
        end
    end
// ----------------------------------------
// phase loss
// ----------------------------------------
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_input_phase_loss_fault <= 1'b0;
            o_output_phase_loss_fault <= 1'b0;
        end else begin
            if (pl_cfg[0] && i_in_phase_lost &&
                (i_cur_pct >= `DPS_IN_LOSS_MIN)) begin
                o_input_phase_loss_fault <= 1'b1; // R13
            end else if (reset_req) begin
                o_input_phase_loss_fault <= 1'b0;
            end
            if (pl_cfg[1] && i_out_phase_lost &&
                (i_cur_pct >= `DPS_OUT_LOSS_MIN)) begin
                o_output_phase_loss_fault <= 1'b1; // R14
            end else if (reset_req) begin
                o_output_phase_loss_fault <= 1'b0;
            end
        end
    end
// ----------------------------------------
// over and low torque
// ----------------------------------------
    function sel_active;
        input [1:0] sel;
        input run;
        input at_set;
        begin
            case (sel)
                2'h1: sel_active = run && at_set;
                2'h2: sel_active = run;
                default: sel_active = 1'b0;
            endcase
        end
    endfunction
    wire [15:0] load = (i_ctrl_mode == `DPS_MODE_SV) ?
                       i_torque_pct : i_cur_pct; // R21
    wire ot_on = sel_active(ot_sel, i_running, i_at_set_freq); // R15
    wire lt_on = sel_active(lt_sel, i_running, i_at_set_freq); // R18
    wire ot_hit;
    wire lt_hit;
    dps_timer #(.TICK_CYC(`DPS_DS_CYC), .W(16)) u_ot (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_cond(ot_on && (load > ot_lvl)), // R16
        .i_limit(ot_time),
        .o_hit(ot_hit)
    );
    dps_timer #(.TICK_CYC(`DPS_DS_CYC), .W(16)) u_lt (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_cond(lt_on && (load < lt_lvl)), // R19
        .i_limit(lt_time),
        .o_hit(lt_hit)
    );
    reg ot_coast;
    reg lt_coast;
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_ot_fault <= 1'b0;
            o_ot_alarm <= 1'b0;
            o_lt_fault <= 1'b0;
            o_lt_alarm <= 1'b0;
            ot_coast <= 1'b0;
            lt_coast <= 1'b0;
        end else begin
            o_ot_alarm <= ot_hit && (ot_act == 2'h1); // R17
            o_lt_alarm <= lt_hit && (lt_act == 2'h1); // R20
            if (ot_hit && (ot_act != 2'h1)) begin
                o_ot_fault <= 1'b1; // R17
                ot_coast <= (ot_act == 2'h2); // R17
            end else if (reset_req) begin
                o_ot_fault <= 1'b0;
                ot_coast <= 1'b0;
            end
            if (lt_hit && (lt_act != 2'h1)) begin
                o_lt_fault <= 1'b1; // R20
                lt_coast <= (lt_act == 2'h2); // R20
            end else if (reset_req) begin
                o_lt_fault <= 1'b0;
                lt_coast <= 1'b0;
            end
        end
    end
// ----------------------------------------
// outputs and relays
// ----------------------------------------
    wire coast_trip = o_motor_overload_fault || o_input_phase_loss_fault ||
                      o_output_phase_loss_fault ||
                      (o_ot_fault && ot_coast) || (o_lt_fault && lt_coast);
    assign o_output_off = coast_trip; // R11 R13 R14
    assign o_decel_stop = (o_ot_fault && !ot_coast) ||
                          (o_lt_fault && !lt_coast);
    assign o_fault_contact = coast_trip || o_decel_stop; // R13 R14
    wire torque_det = ot_hit || lt_hit;
    genvar g;
    generate
        for (g = 0; g < N_RELAY; g = g + 1) begin : g_relay
            wire [4:0] fn = relay_fn[5*g +: 5];
            always @(posedge i_mclk) begin
                if (i_rst) begin
                    o_relay[g] <= 1'b0;
                end else begin
                    o_relay[g] <= torque_det &&
                        ((fn == `DPS_FN_TORQUE_A) ||
                         (fn == `DPS_FN_TORQUE_B)); // R22
                end
            end
        end
    endgenerate
    assign status = {5'h00, o_stall_recover, o_stall_decel, lt_hit, ot_hit,
                     o_lt_alarm, o_lt_fault, o_ot_alarm, o_ot_fault,
                     o_output_phase_loss_fault, o_input_phase_loss_fault,
                     o_motor_overload_fault | o_overload_alarm};
endmodule

// [src/dps_timer.v]
// detection timer: counts while the condition holds, restarts when it drops
`timescale 1ns/1ps
module dps_timer #(
    parameter TICK_CYC = 1000,
    parameter W = 16
) (
    input wire i_mclk,
    input wire i_rst,
    input wire i_cond,
    input wire [W-1:0] i_limit,
    output reg o_hit
);
    reg [31:0] pre;
    reg [W-1:0] ticks;
    always @(posedge i_mclk) begin
        if (i_rst || !i_cond) begin
            pre <= 32'h0; // R23
            ticks <= {W{1'b0}}; // R23
            o_hit <= 1'b0;
        end else if (ticks >= i_limit) begin
            o_hit <= 1'b1;
        end else if (pre == TICK_CYC - 1) begin
            pre <= 32'h0;
            ticks <= ticks + 1'b1;
        end else begin
            pre <= pre + 32'h1;
        end
    end
endmodule

// [verification/dps_monitor.sv]
// concurrent checks on the supervisor ports
`timescale 1ns/1ps
module dps_monitor (
    input wire i_mclk,
    input wire i_rst,
    input wire [3:0] i_addr,
    input wire i_rd,
    input wire [15:0] o_rdata,
    input wire [1:0] i_ctrl_mode,
    input wire [15:0] i_cur_pct,
    input wire i_wr,
    input wire i_fault_reset,
    input wire o_output_off,
    input wire o_decel_stop,
    input wire o_fault_contact,
    input wire o_motor_overload_fault,
    input wire o_overload_alarm,
    input wire o_input_phase_loss_fault,
    input wire o_output_phase_loss_fault,
    input wire o_ot_fault,
    input wire o_ot_alarm,
    input wire o_stall_decel
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    sequence s_rd_unmapped;
        i_rd && i_addr == 4'hf;
    endsequence
    sequence s_zero_answer;
        o_rdata == 16'h0000;
    endsequence
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("stray read data");
    a_unmapped_rd: assert property (s_rd_unmapped |=> s_zero_answer)
        else $error("unmapped read");
    a_in_loss_trip: assert property (o_input_phase_loss_fault |->
        o_fault_contact && o_output_off)
        else $error("input loss no stop");
    a_in_loss_gate: assert property ($rose(o_input_phase_loss_fault) |->
        $past(i_cur_pct) >= 16'h001e)
        else $error("input loss at low current");
    a_out_loss_trip: assert property (o_output_phase_loss_fault |->
        o_fault_contact && o_output_off)
        else $error("output loss no stop");
    a_out_loss_gate: assert property ($rose(o_output_phase_loss_fault) |->
        $past(i_cur_pct) >= 16'h000a)
        else $error("output loss at low current");
    a_mol_stop: assert property (o_motor_overload_fault |-> o_output_off)
        else $error("overload left output on");
    a_mol_latch: assert property (o_motor_overload_fault &&
        !i_fault_reset && !$past(i_wr) |=> o_motor_overload_fault)
        else $error("overload fault dropped");
    a_mol_alarm_only: assert property (o_overload_alarm |->
        !o_motor_overload_fault && !o_output_off)
        else $error("alarm stopped the drive");
    a_ot_excl: assert property (o_ot_alarm |-> !o_ot_fault)
        else $error("torque alarm with fault");
    a_ot_fault_stop: assert property (o_ot_fault |->
        o_fault_contact && (o_output_off || o_decel_stop))
        else $error("torque fault no stop");
    a_stall_mode: assert property ($rose(o_stall_decel) |->
        $past(i_ctrl_mode) == 2'h0 || $past(i_ctrl_mode) == 2'h2)
        else $error("stall in wrong mode");
endmodule
bind dps_supervisor dps_monitor mon (.*);

// [verification/dps_power_stage.sv]
// power stage model feeding the supervisor
`timescale 1ns/1ps
module dps_power_stage (
    input wire i_mclk,
    input wire i_run_cmd,
    input wire i_at_set_cmd,
    input wire i_output_off,
    input wire [15:0] i_cur_set,
    input wire [15:0] i_freq_set,
    input wire i_lin,
    input wire i_lout,
    output reg o_running,
    output reg o_at_set_freq,
    output reg [15:0] o_cur_pct,
    output reg [15:0] o_torque_pct,
    output reg [15:0] o_freq_dhz,
    output reg o_in_phase_lost,
    output reg o_out_phase_lost
);
    // no current once the output is off
    always @(posedge i_mclk) begin
        o_running <= i_run_cmd && !i_output_off;
        o_at_set_freq <= i_at_set_cmd && !i_output_off;
        o_cur_pct <= i_output_off ? 16'h0000 : i_cur_set;
        o_torque_pct <= i_output_off ? 16'h0000 : i_cur_set;
        o_freq_dhz <= i_output_off ? 16'h0000 : i_freq_set;
        o_in_phase_lost <= i_lin;
        o_out_phase_lost <= i_lout;
    end
endmodule

// [verification/tb_top.sv]
// bench for the protection supervisor
`timescale 1ns/1ps
`include "dps_map.vh"
module tb_top;
    reg i_mclk, i_rst, i_wr, i_rd, i_accel, i_fault_reset;
    reg [3:0] i_addr;
    reg [15:0] i_wdata, cur_set, freq_set, rdv;
    reg [1:0] i_ctrl_mode;
    reg run_cmd, at_set_cmd, lin, lout;
    wire running, at_set, inl, outl, o_output_off, o_decel_stop;
    wire [15:0] cur, trq, freq, o_rdata;
    wire o_stall_decel, o_stall_decel2, o_stall_recover, o_fault_contact;
    wire o_mol, o_ola, o_lin, o_lout, o_otf, o_ota, o_ltf, o_lta;
    wire [2:0] o_relay;
    integer err_count, n_compared, cyc, k;
    dps_supervisor #(.N_RELAY(3), .COLD_CYC(1000), .HOT_CYC(600)) uut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_ctrl_mode(i_ctrl_mode), .i_running(running),
        .i_at_set_freq(at_set), .i_accel(i_accel), .i_cur_pct(cur),
        .i_torque_pct(trq), .i_freq_dhz(freq), .i_in_phase_lost(inl),
        .i_out_phase_lost(outl), .i_fault_reset(i_fault_reset),
        .o_stall_decel(o_stall_decel), .o_stall_decel2(o_stall_decel2),
        .o_stall_recover(o_stall_recover), .o_output_off(o_output_off),
        .o_decel_stop(o_decel_stop), .o_fault_contact(o_fault_contact),
        .o_motor_overload_fault(o_mol), .o_overload_alarm(o_ola),
        .o_input_phase_loss_fault(o_lin), .o_output_phase_loss_fault(o_lout),
        .o_ot_fault(o_otf), .o_ot_alarm(o_ota), .o_lt_fault(o_ltf),
        .o_lt_alarm(o_lta), .o_relay(o_relay));
    dps_power_stage ps (
        .i_mclk(i_mclk), .i_run_cmd(run_cmd), .i_at_set_cmd(at_set_cmd),
        .i_output_off(o_output_off), .i_cur_set(cur_set),
        .i_freq_set(freq_set), .i_lin(lin), .i_lout(lout),
        .o_running(running), .o_at_set_freq(at_set), .o_cur_pct(cur),
        .o_torque_pct(trq), .o_freq_dhz(freq), .o_in_phase_lost(inl),
        .o_out_phase_lost(outl));
    //----------
    // shared tasks
    //----------
    task tick(input integer n);
        repeat (n) @(posedge i_mclk);
    endtask
    task wr(input [3:0] a, input [15:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task rd(input [3:0] a, output [15:0] d);
        @(posedge i_mclk);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            err_count = err_count + 1;
        end
    endtask
    task set_cur(input [15:0] c, input integer n);
        @(posedge i_mclk);
        cur_set <= c;
        tick(n);
    endtask
    task clear_faults;
        set_cur(16'h0032, 3);
        wr(`DPS_A_CTRL, 16'h0001);
        tick(3);
    endtask
    task give_verdict;
        $display("compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    //----------
    // scenarios
    //----------
    task t_regs;
        rd(`DPS_A_STALL_LVL, rdv); chk(rdv, `DPS_STALL_LVL_RST);
        rd(`DPS_A_OT_LVL, rdv); chk(rdv, `DPS_OT_LVL_RST);
        rd(`DPS_A_LT_LVL, rdv); chk(rdv, `DPS_LT_LVL_RST);
        rd(`DPS_A_OL_CFG, rdv); chk(rdv, 16'h0001);
        wr(`DPS_A_STALL_LVL, 16'h0078);
        rd(`DPS_A_STALL_LVL, rdv); chk(rdv, 16'h0078);
        rd(`DPS_A_RELAY, rdv); chk(rdv, 16'h0000);
        rd(4'hf, rdv); chk(rdv, 16'h0000);
    endtask
    task t_stall;
        wr(`DPS_A_STALL_TIME, 16'h0000);
        set_cur(16'h0079, 10); chk(o_stall_decel, 1'b1);
        chk(o_stall_decel2, 1'b0);
        set_cur(16'h0076, 10); chk(o_stall_decel, 1'b1);
        set_cur(16'h0075, 10); chk(o_stall_decel, 1'b0);
        chk(o_stall_recover, 1'b1);
        wr(`DPS_A_STALL_CFG, 16'h0008);
        set_cur(16'h0079, 10); chk(o_stall_decel2, 1'b1);
        set_cur(16'h0064, 10);
        wr(`DPS_A_STALL_CFG, 16'h0004);
        set_cur(16'h0079, 10); chk(o_stall_decel, 1'b0);
        set_cur(16'h0064, 3);
        wr(`DPS_A_STALL_CFG, 16'h0000);
        i_ctrl_mode <= 2'h1;
        set_cur(16'h0079, 10); chk(o_stall_decel, 1'b0);
        i_ctrl_mode <= 2'h2;
        tick(10); chk(o_stall_decel, 1'b1);
        set_cur(16'h0064, 10);
        i_ctrl_mode <= 2'h0;
    endtask
    task t_phase;
        wr(`DPS_A_PL_CFG, 16'h0003);
        set_cur(16'h001d, 2);
        lin <= 1'b1;
        tick(20); chk(o_lin, 1'b0);
        set_cur(16'h001e, 20); chk(o_lin, 1'b1);
        chk({o_fault_contact, o_output_off}, 2'b11);
        lin <= 1'b0;
        clear_faults; chk(o_lin, 1'b0);
        set_cur(16'h0009, 2);
        lout <= 1'b1;
        tick(20); chk(o_lout, 1'b0);
        set_cur(16'h000a, 20); chk(o_lout, 1'b1);
        chk({o_fault_contact, o_output_off}, 2'b11);
        lout <= 1'b0;
        clear_faults;
        wr(`DPS_A_PL_CFG, 16'h0000);
        lin <= 1'b1;
        tick(20); chk(o_lin, 1'b0);
        lin <= 1'b0;
    endtask
    task t_torque;
        wr(`DPS_A_RELAY, 16'h000c);
        wr(`DPS_A_RELAY, 16'h1019);
        wr(`DPS_A_OT_LVL, 16'h0064);
        wr(`DPS_A_OT_TIME, 16'h0000);
        // flags for actions 0..2
        for (k = 0; k < 3; k = k + 1) begin
            clear_faults;
            wr(`DPS_A_OT_CFG, (k << 4) | 2);
            set_cur(16'h0065, 20);
            chk({o_otf, o_ota, o_decel_stop, o_output_off},
                (k == 0) ? 4'ha : (k == 1) ? 4'h4 : 4'h9);
            if (k == 1) chk(o_relay, 3'b011);
        end
        clear_faults;
        wr(`DPS_A_OT_CFG, 16'h0010);
        set_cur(16'h0065, 20); chk(o_ota, 1'b0);
        wr(`DPS_A_OT_CFG, 16'h0011);
        tick(20); chk(o_ota, 1'b0);
        at_set_cmd <= 1'b1;
        tick(20); chk(o_ota, 1'b1);
        clear_faults;
        wr(`DPS_A_OT_CFG, 16'h0000);
        wr(`DPS_A_LT_TIME, 16'h0000);
        wr(`DPS_A_LT_CFG, 16'h0012);
        set_cur(16'h001d, 20); chk(o_lta, 1'b1);
        chk(o_ltf, 1'b0);
        clear_faults;
        wr(`DPS_A_LT_CFG, 16'h0000);
    endtask
    task t_overload;
        i_rst <= 1'b1;
        tick(2);
        i_rst <= 1'b0;
        freq_set <= 16'h0262;
        wr(`DPS_A_OL_CFG, 16'h0003);
        set_cur(16'h0096, 540); chk(o_mol, 1'b0);
        tick(120); chk({o_mol, o_output_off}, 2'b11);
        set_cur(16'h0032, 50); chk(o_mol, 1'b1);
        i_fault_reset <= 1'b1;
        tick(2);
        i_fault_reset <= 1'b0;
        tick(3); chk(o_mol, 1'b0);
        i_rst <= 1'b1;
        tick(2);
        i_rst <= 1'b0;
        wr(`DPS_A_OL_ACT, 16'h0001);
        wr(`DPS_A_OL_CFG, 16'h0001);
        set_cur(16'h0096, 940); chk(o_ola, 1'b0);
        tick(120); chk({o_ola, o_mol, o_output_off}, 3'b100);
        set_cur(16'h0032, 10); chk(o_ola, 1'b0);
    endtask
    //----------
    // clock, reset, timeout and main sequence
    //----------
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            give_verdict;
        end
    end
    initial begin
        err_count = 0; n_compared = 0; cyc = 0;
        i_rst = 1'b1; i_wr = 1'b0; i_rd = 1'b0; i_addr = 4'h0;
        i_wdata = 16'h0000; i_accel = 1'b0; i_fault_reset = 1'b0;
        i_ctrl_mode = 2'h0; run_cmd = 1'b1; at_set_cmd = 1'b0;
        cur_set = 16'h0064; freq_set = 16'h01f4; lin = 1'b0; lout = 1'b0;
        tick(20);
        i_rst <= 1'b0;
        t_regs;
        t_stall;
        t_phase;
        t_torque;
        t_overload;
        give_verdict;
    end
endmodule
